// ===== cctr_regs_bank.v
// charger control five, reserved and thermal control register bank
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "cctr_regs.vh"

// Functional notes
// - unfitted ship switch forces three fields zero
// - fitted bit set unlocks ship-related fields
// - current monitor output enable, watchdog clears
// - control five resets 0x16, fixed reserved bits
// - internal input limit enable, default one
// - external limit enable, register reset only
// - discharge overcurrent enable, default zero
// - reserved register always reads zero
// - thermal register resets 0xC0, bit0 zero
// - regulation threshold 60/80/100/120 C
// - shutdown threshold 150/130/120/85 C
// - input bus pull-down, register reset only
// - source one pull-down, register reset only
// - source two pull-down, register reset only
module cctr_regs_bank (
    input wire clk,
    input wire rst,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    input wire wdTimeout,
    output wire shipSwitchFitted,
    output wire battDischargeOcpEn,
    output wire shipSwitchForceOff,
    output wire [1:0] shipDriveCtrl,
    output wire battCurrentOutEn,
    output wire intInputLimitEn,
    output wire extInputLimitEn,
    output wire [1:0] thermalRegThresh,
    output wire [1:0] thermalTripThresh,
    output wire inputBusPulldownEn,
    output wire src1PulldownEn,
    output wire src2PulldownEn,
    output reg [7:0] thermalRegDegC,
    output reg [7:0] thermalTripDegC
);

    // word address match against a register index
    function hitIdx;
        input [7:0] adr;
        input [7:0] idx;
        begin
            hitIdx = (adr[1:0] == 2'h0) && (adr[7:2] == idx[5:0]);
        end
    endfunction

    // code to degrees for the regulation threshold
    function [7:0] tregDeg;
        input [1:0] code;
        begin
            case (code)
                2'h0: tregDeg = `CCTR_TREG_C0;
                2'h1: tregDeg = `CCTR_TREG_C1;
                2'h2: tregDeg = `CCTR_TREG_C2;
                default: tregDeg = `CCTR_TREG_C3;
            endcase
        end
    endfunction

    // code to degrees for the shutdown threshold
    function [7:0] tshutDeg;
        input [1:0] code;
        begin
            case (code)
                2'h0: tshutDeg = `CCTR_TSHUT_C0;
                2'h1: tshutDeg = `CCTR_TSHUT_C1;
                2'h2: tshutDeg = `CCTR_TSHUT_C2;
                default: tshutDeg = `CCTR_TSHUT_C3;
            endcase
        end
    endfunction

    reg ack_r;
    // stored fields; reserved bits have no flops
    reg fitted_r;
    reg battCur_r;
    reg intLim_r;
    reg extLim_r;
    reg ocp_r;
    reg forceOff_r;
    reg [1:0] drive_r;
    reg [1:0] treg_r;
    reg [1:0] tshut_r;
    reg busPd_r;
    reg src1Pd_r;
    reg src2Pd_r;

    reg fitted_nxt;
    reg battCur_nxt;
    reg intLim_nxt;
    reg extLim_nxt;
    reg ocp_nxt;
    reg forceOff_nxt;
    reg [1:0] drive_nxt;
    reg [1:0] treg_nxt;
    reg [1:0] tshut_nxt;
    reg busPd_nxt;
    reg src1Pd_nxt;
    reg src2Pd_nxt;
    reg [7:0] rdByte;

    // bus request and per-register write strobes
    wire req;
    wire rdTake;
    wire wrEn;
    wire wrC5;
    wire wrTh;
    wire wrShip;
    wire regRst;
    wire [7:0] ctrl5Val;
    wire [7:0] thermVal;
    wire [7:0] shipVal;

    // power-on value of control five, shared by both reset paths
    localparam [7:0] CTRL5_DEF = `CCTR_RST_CTRL5;

    assign req = cyc_i & stb_i;
    // read data is captured as the request is taken
    assign rdTake = req & ~ack_r & ~we_i;
    // writes land on the edge where ack is seen high
    assign wrEn = req & we_i & ack_r & sel_i[0];
    assign wrC5 = wrEn & hitIdx(adr_i, `CCTR_IDX_CTRL5);
    assign wrTh = wrEn & hitIdx(adr_i, `CCTR_IDX_THERM);
    assign wrShip = wrEn & hitIdx(adr_i, `CCTR_IDX_SHIP);
    assign regRst = wrEn & hitIdx(adr_i, `CCTR_IDX_CMD)
                  & dat_i[`CCTR_CMD_REGRST];
    assign ack_o = ack_r;

    // reserved bits are constants, never stored
    assign ctrl5Val = {fitted_r, 1'b0, battCur_r, `CCTR_C5_RSVD_VAL,
                       intLim_r, extLim_r, ocp_r};
    assign thermVal = {treg_r, tshut_r, busPd_r, src1Pd_r, src2Pd_r,
                       1'b0};
    // own ship control word; the lock applies to it as well
    assign shipVal = {5'h00, drive_r, forceOff_r};

    // priority: register reset, then watchdog, then bus writes
    always @* begin
        fitted_nxt = fitted_r;
        battCur_nxt = battCur_r;
        intLim_nxt = intLim_r;
        extLim_nxt = extLim_r;
        ocp_nxt = ocp_r;
        forceOff_nxt = forceOff_r;
        drive_nxt = drive_r;
        treg_nxt = treg_r;
        tshut_nxt = tshut_r;
        busPd_nxt = busPd_r;
        src1Pd_nxt = src1Pd_r;
        src2Pd_nxt = src2Pd_r;
        if (regRst) begin
            // every stored field, fitted bit included
            fitted_nxt = CTRL5_DEF[`CCTR_C5_FITTED];
            battCur_nxt = 1'b0;
            intLim_nxt = 1'b1;
            extLim_nxt = 1'b1;
            ocp_nxt = 1'b0;
            forceOff_nxt = 1'b0;
            drive_nxt = 2'h0;
            treg_nxt = `CCTR_RST_TREG;
            tshut_nxt = `CCTR_RST_TSHUT;
            busPd_nxt = 1'b0;
            src1Pd_nxt = 1'b0;
            src2Pd_nxt = 1'b0;
        end else if (wdTimeout) begin
            // pull-downs, external limit and fitted bit survive
            battCur_nxt = 1'b0;
            intLim_nxt = 1'b1;
            ocp_nxt = 1'b0;
            treg_nxt = `CCTR_RST_TREG;
            tshut_nxt = `CCTR_RST_TSHUT;
        end else begin
            // bus writes only while neither reset acts
            if (wrC5) begin
                fitted_nxt = dat_i[`CCTR_C5_FITTED];
                battCur_nxt = dat_i[`CCTR_C5_BATTCUR];
                intLim_nxt = dat_i[`CCTR_C5_INTLIM];
                extLim_nxt = dat_i[`CCTR_C5_EXTLIM];
                ocp_nxt = dat_i[`CCTR_C5_OCP];
            end
            if (wrShip) begin
                forceOff_nxt = dat_i[`CCTR_SH_FORCE];
                drive_nxt = dat_i[`CCTR_SH_DRV_HI:`CCTR_SH_DRV_LO];
            end
            if (wrTh) begin
                treg_nxt = dat_i[`CCTR_TH_REG_HI:`CCTR_TH_REG_LO];
                tshut_nxt = dat_i[`CCTR_TH_TRIP_HI:`CCTR_TH_TRIP_LO];
                busPd_nxt = dat_i[`CCTR_TH_BUSPD];
                src1Pd_nxt = dat_i[`CCTR_TH_SRC1PD];
                src2Pd_nxt = dat_i[`CCTR_TH_SRC2PD];
            end
        end
        // lock-out follows the fitted value being stored
        if (!fitted_nxt) begin
            ocp_nxt = 1'b0;
            forceOff_nxt = 1'b0;
            drive_nxt = 2'h0;
        end
    end

    // read decode; unmapped words and the reserved register read zero
    always @* begin
        if (hitIdx(adr_i, `CCTR_IDX_CTRL5)) begin
            rdByte = ctrl5Val;
        end else if (hitIdx(adr_i, `CCTR_IDX_RSVD)) begin
            rdByte = `CCTR_RST_RSVD;
        end else if (hitIdx(adr_i, `CCTR_IDX_THERM)) begin
            rdByte = thermVal;
        end else if (hitIdx(adr_i, `CCTR_IDX_SHIP)) begin
            rdByte = shipVal;
        end else begin
            rdByte = 8'h00;
        end
    end

    // ack for one cycle, then low so a held request is not taken twice
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // read data held until the next read is taken
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_o <= 32'h0000_0000;
        end else if (rdTake) begin
            dat_o <= {24'h000000, rdByte};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fitted_r <= CTRL5_DEF[`CCTR_C5_FITTED];
            battCur_r <= 1'b0;
            intLim_r <= 1'b1;
            extLim_r <= 1'b1;
            ocp_r <= 1'b0;
            forceOff_r <= 1'b0;
            drive_r <= 2'h0;
            treg_r <= `CCTR_RST_TREG;
            tshut_r <= `CCTR_RST_TSHUT;
            busPd_r <= 1'b0;
            src1Pd_r <= 1'b0;
            src2Pd_r <= 1'b0;
        end else begin
            fitted_r <= fitted_nxt;
            battCur_r <= battCur_nxt;
            intLim_r <= intLim_nxt;
            extLim_r <= extLim_nxt;
            ocp_r <= ocp_nxt;
            forceOff_r <= forceOff_nxt;
            drive_r <= drive_nxt;
            treg_r <= treg_nxt;
            tshut_r <= tshut_nxt;
            busPd_r <= busPd_nxt;
            src1Pd_r <= src1Pd_nxt;
            src2Pd_r <= src2Pd_nxt;
        end
    end

    // temperatures registered so they track the stored codes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            thermalRegDegC <= `CCTR_TREG_C3;
            thermalTripDegC <= `CCTR_TSHUT_C0;
        end else begin
            thermalRegDegC <= tregDeg(treg_nxt);
            thermalTripDegC <= tshutDeg(tshut_nxt);
        end
    end

    // level outputs straight from their flops
    assign shipSwitchFitted = fitted_r;
    assign battDischargeOcpEn = ocp_r;
    assign shipSwitchForceOff = forceOff_r;
    assign shipDriveCtrl = drive_r;
    assign battCurrentOutEn = battCur_r;
    assign intInputLimitEn = intLim_r;
    assign extInputLimitEn = extLim_r;
    assign thermalRegThresh = treg_r;
    assign thermalTripThresh = tshut_r;
    assign inputBusPulldownEn = busPd_r;
    assign src1PulldownEn = src1Pd_r;
    assign src2PulldownEn = src2Pd_r;

endmodule // cctr_regs_bank
`default_nettype wire

// ===== cctr_regs.vh
// register map, field positions, reset values and codes for cctr block
`ifndef CCTR_REGS_VH
`define CCTR_REGS_VH

// register indices as printed; byte address is four times the index
`define CCTR_IDX_CTRL5 8'h14
`define CCTR_IDX_RSVD 8'h15
`define CCTR_IDX_THERM 8'h16
`define CCTR_IDX_CMD 8'h00
`define CCTR_IDX_SHIP 8'h01

// control five fields
`define CCTR_C5_FITTED 7
`define CCTR_C5_RSVD6 6
`define CCTR_C5_BATTCUR 5
`define CCTR_C5_RSVD_HI 4
`define CCTR_C5_RSVD_LO 3
`define CCTR_C5_INTLIM 2
`define CCTR_C5_EXTLIM 1
`define CCTR_C5_OCP 0
`define CCTR_C5_RSVD_VAL 2'h2

// thermal control fields
`define CCTR_TH_REG_HI 7
`define CCTR_TH_REG_LO 6
`define CCTR_TH_TRIP_HI 5
`define CCTR_TH_TRIP_LO 4
`define CCTR_TH_BUSPD 3
`define CCTR_TH_SRC1PD 2
`define CCTR_TH_SRC2PD 1

// ship control fields and command bit
`define CCTR_SH_FORCE 0
`define CCTR_SH_DRV_HI 2
`define CCTR_SH_DRV_LO 1
`define CCTR_CMD_REGRST 0

// reset values
`define CCTR_RST_CTRL5 8'h16
`define CCTR_RST_RSVD 8'h00
`define CCTR_RST_THERM 8'hC0
`define CCTR_RST_TREG 2'h3
`define CCTR_RST_TSHUT 2'h0

// threshold temperatures in degrees C
`define CCTR_TREG_C0 8'h3C
`define CCTR_TREG_C1 8'h50
`define CCTR_TREG_C2 8'h64
`define CCTR_TREG_C3 8'h78
`define CCTR_TSHUT_C0 8'h96
`define CCTR_TSHUT_C1 8'h82
`define CCTR_TSHUT_C2 8'h78
`define CCTR_TSHUT_C3 8'h55

`endif

// ===== cctr_regs_bank_sva.sv
// assertion checker for the charger control and thermal register bank
`timescale 1ns/1ns
`default_nettype none
module cctr_regs_bank_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic wdTimeout,
    input wire logic shipSwitchFitted,
    input wire logic battDischargeOcpEn,
    input wire logic shipSwitchForceOff,
    input wire logic [1:0] shipDriveCtrl,
    input wire logic battCurrentOutEn,
    input wire logic intInputLimitEn,
    input wire logic extInputLimitEn,
    input wire logic [1:0] thermalRegThresh,
    input wire logic [1:0] thermalTripThresh,
    input wire logic inputBusPulldownEn,
    input wire logic [7:0] thermalRegDegC,
    input wire logic [7:0] thermalTripDegC
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    function automatic logic [7:0] tripC(input logic [1:0] c);
        case (c)
            2'h0: tripC = 8'h96;
            2'h1: tripC = 8'h82;
            2'h2: tripC = 8'h78;
            default: tripC = 8'h55;
        endcase
    endfunction
    wire rdAck = ack_o && !we_i;
    property p_lock;
        !shipSwitchFitted |-> !battDischargeOcpEn && !shipSwitchForceOff
            && shipDriveCtrl == 2'h0;
    endproperty
    property p_wdClr;
        wdTimeout |=> !battCurrentOutEn && intInputLimitEn
            && !battDischargeOcpEn;
    endproperty
    property p_wdTherm;
        wdTimeout |=> thermalRegThresh == 2'h3 && thermalTripThresh == 2'h0;
    endproperty
    property p_wdKeep;
        wdTimeout && !ack_o |=> $stable(extInputLimitEn)
            && $stable(inputBusPulldownEn);
    endproperty
    property p_regDeg;
        thermalRegDegC == 8'h3C + 8'h14 * {6'h00, thermalRegThresh};
    endproperty
    property p_tripDeg;
        thermalTripDegC == tripC(thermalTripThresh);
    endproperty
    property p_rsvdRead;
        rdAck && adr_i == 8'h54 |-> dat_o == 32'h0;
    endproperty
    property p_ctrlBits;
        rdAck && adr_i == 8'h50 |-> dat_o[4:3] == 2'h2 && !dat_o[6];
    endproperty
    property p_thermBit;
        rdAck && adr_i == 8'h58 |-> !dat_o[0] && dat_o[31:8] == 24'h0;
    endproperty
    property p_ackLat;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_lock: assert property (p_lock) else $error("ship fields not locked");
    a_wdClr: assert property (p_wdClr) else $error("watchdog clear wrong");
    a_wdTherm: assert property (p_wdTherm) else $error("watchdog therm wrong");
    a_wdKeep: assert property (p_wdKeep) else $error("watchdog hit field");
    a_regDeg: assert property (p_regDeg) else $error("regulation deg wrong");
    a_tripDeg: assert property (p_tripDeg) else $error("shutdown deg wrong");
    a_rsvdRead: assert property (p_rsvdRead) else $error("reserved not zero");
    a_ctrlBits: assert property (p_ctrlBits) else $error("ctrl fixed bits");
    a_thermBit: assert property (p_thermBit) else $error("therm bit0 set");
    a_ackLat: assert property (p_ackLat) else $error("ack timing wrong");
    c_wd: cover property (wdTimeout);
    c_wr: cover property (ack_o && we_i);
    c_ocp: cover property (shipSwitchFitted && battDischargeOcpEn);
endmodule // cctr_regs_bank_sva
bind cctr_regs_bank cctr_regs_bank_sva u_sva (.clk, .rst, .cyc_i, .stb_i,
    .we_i, .adr_i, .dat_o, .ack_o, .wdTimeout, .shipSwitchFitted,
    .battDischargeOcpEn, .shipSwitchForceOff, .shipDriveCtrl,
    .battCurrentOutEn, .intInputLimitEn, .extInputLimitEn, .thermalRegThresh,
    .thermalTripThresh, .inputBusPulldownEn, .thermalRegDegC,
    .thermalTripDegC);
`default_nettype wire

// ===== cctr_regs_bank_tb.sv
// testbench for the charger control and thermal register bank
`timescale 1ns/1ns
`default_nettype none
module cctr_regs_bank_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic wd = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] datI = 32'h0;
    logic [31:0] datO;
    logic ackO;
    logic [7:0] degR;
    logic [7:0] degT;
    logic [7:0] q;
    logic [3:0] sel = 4'h0;
    logic [3:0] selUse = 4'h1;
    wire [14:0] pin;
    logic [7:0] tR [4] = '{8'h3C, 8'h50, 8'h64, 8'h78};
    logic [7:0] tT [4] = '{8'h96, 8'h82, 8'h78, 8'h55};
    int numErrors = 0;
    int samplesChecked = 0;
    always #5 clk = ~clk;
    cctr_regs_bank dut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO),
        .ack_o(ackO), .wdTimeout(wd), .shipSwitchFitted(pin[14]),
        .battDischargeOcpEn(pin[13]), .shipSwitchForceOff(pin[12]),
        .shipDriveCtrl(pin[11:10]), .battCurrentOutEn(pin[9]),
        .intInputLimitEn(pin[8]), .extInputLimitEn(pin[7]),
        .thermalRegThresh(pin[6:5]), .thermalTripThresh(pin[4:3]),
        .inputBusPulldownEn(pin[2]), .src1PulldownEn(pin[1]),
        .src2PulldownEn(pin[0]), .thermalRegDegC(degR),
        .thermalTripDegC(degT));
    task automatic results;
        if (numErrors == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkPin(input logic [14:0] got, input logic [14:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= selUse;
        adr <= a;
        datI <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ackO !== 1'b1 && n < 20);
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        if (n >= 20) begin
            chk({7'h0, ackO}, 8'h01);
            results;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic t_defaults;
        rd(8'h50, 8'h16);
        rd(8'h54, 8'h00);
        rd(8'h58, 8'hC0);
        chk(degR, 8'h78);
        chk(degT, 8'h96);
        chkPin(pin, 15'h01E0);
    endtask
    task automatic t_ship;
        xfer(1'b1, 8'h50, 8'h7F);
        rd(8'h50, 8'h36);
        xfer(1'b1, 8'h04, 8'h07);
        rd(8'h04, 8'h00);
        xfer(1'b1, 8'h50, 8'h81);
        rd(8'h50, 8'h91);
        xfer(1'b1, 8'h04, 8'h07);
        rd(8'h04, 8'h07);
        xfer(1'b1, 8'h54, 8'hFF);
        rd(8'h54, 8'h00);
        chkPin(pin, 15'h7C60);
    endtask
    task automatic t_wd;
        xfer(1'b1, 8'h50, 8'hA1);
        rd(8'h50, 8'hB1);
        xfer(1'b1, 8'h58, 8'hFF);
        rd(8'h58, 8'hFE);
        @(posedge clk);
        wd <= 1'b1;
        @(posedge clk);
        wd <= 1'b0;
        rd(8'h50, 8'h94);
        rd(8'h58, 8'hCE);
        chkPin(pin, 15'h5D67);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 8'h58, {c[1:0], c[1:0], 4'h0});
            rd(8'h58, {c[1:0], c[1:0], 4'h0});
            chk(degR, tR[c]);
            chk(degT, tT[c]);
        end
    endtask
    task automatic t_soft;
        selUse = 4'h0;
        xfer(1'b1, 8'h58, 8'h0E);
        selUse = 4'h1;
        rd(8'h58, 8'hF0);
        xfer(1'b1, 8'h50, 8'hFF);
        xfer(1'b1, 8'h00, 8'h01);
        rd(8'h50, 8'h16);
        rd(8'h58, 8'hC0);
        rd(8'h80, 8'h00);
        chkPin(pin, 15'h01E0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_defaults;
        t_ship;
        t_wd;
        t_codes;
        t_soft;
        results;
    end
endmodule // cctr_regs_bank_tb
`default_nettype wire
